// >>> pkg/padc_pkg.sv
// Constants, types and register map of the pipelined converter output control
// Contract
// - Sample frozen on encode rise; low acquires
// - Encode high means positive input above negative
// - Result appears seven encode cycles later
// - Five stage results delayed, merged before output
// - Sixteen-bit word, bit 15 is MSB
// - Data valid toggles per sample; latch falling
// - Inverted data valid complements it; latch rising
// - Overflow high when input beyond full scale
// - Output enable low drives, high floats
// - Power down low floats outputs, halts conversion
// - Dither enable high turns dither on
// - Mode selects coding and duty stabilizer
// - Scramble high XORs bits 15..1 with bit 0
// - Gain select low unity, high gain 1.5
// - Two's complement mid-scale codes zeros and ones
package padc_pkg;

    localparam int PADC_WORD_W = 16;
    localparam int PADC_LATENCY = 7;
    localparam int PADC_STAGES = 5;
    localparam int PADC_SYNC_W = 9;

    // Stage field widths and their bit positions in the merged word
    localparam int PADC_STAGE_W [PADC_STAGES] = '{4, 3, 3, 3, 3};
    localparam int PADC_STAGE_LSB [PADC_STAGES] = '{12, 9, 6, 3, 0};

    // Register byte offsets
    localparam logic [7:0] PADC_OFS_CTRL = 8'h00;
    localparam logic [7:0] PADC_OFS_STATUS = 8'h04;
    localparam logic [7:0] PADC_OFS_MASK = 8'h08;
    localparam logic [7:0] PADC_OFS_LAST = 8'h0C;
    localparam logic [7:0] PADC_OFS_PINS = 8'h10;
    localparam logic [7:0] PADC_OFS_COUNT = 8'h14;

    // Status and mask bit positions
    localparam int PADC_EV_WORD = 0;
    localparam int PADC_EV_RANGE = 1;
    localparam int PADC_EV_W = 2;

    // Reset values
    localparam logic [PADC_EV_W-1:0] PADC_MASK_RST = 2'h0;
    localparam logic PADC_FREEZE_RST = 1'b0;
    localparam logic [PADC_WORD_W-1:0] PADC_WORD_RST = 16'h0000;
    localparam logic [31:0] PADC_COUNT_RST = 32'h0000_0000;

    // Mode levels as digitised by the four-level pin receiver
    localparam logic [1:0] PADC_MODE_OB_NODCS = 2'h0;
    localparam logic [1:0] PADC_MODE_OB_DCS = 2'h1;
    localparam logic [1:0] PADC_MODE_TC_DCS = 2'h2;
    localparam logic [1:0] PADC_MODE_TC_NODCS = 2'h3;

    typedef enum logic [1:0] {
        PADC_ENC_LOW = 2'b01,
        PADC_ENC_HIGH = 2'b10
    } padc_phase_t;

    // One sample in flight: residue not yet resolved, stage fields resolved so far
    typedef struct packed {
        logic [PADC_WORD_W-1:0] residue;
        logic [PADC_WORD_W-1:0] fields;
        logic over;
    } padc_slot_t;

    // Pin levels after the two-flop synchroniser
    typedef struct packed {
        logic enc_pos;
        logic enc_neg;
        logic output_disable;
        logic power_down_n;
        logic dither_en;
        logic scramble;
        logic gain_select;
        logic [1:0] mode;
    } padc_pins_t;

    // Formatted output word as driven on the data pins
    typedef struct packed {
        logic [PADC_WORD_W-1:0] word;
        logic over;
    } padc_out_t;

endpackage

// >>> hdl/padc_output_ctrl.sv
// Converter output path: encode sequencing, stage pipeline, formatting, AHB-Lite registers
`timescale 1ns/1ps
module padc_output_ctrl
    import padc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt
    output logic irq,
    // Encode clock pins
    input wire logic encode_clock_pos,
    input wire logic encode_clock_neg,
    // Converter core result and range detector
    input wire logic [PADC_WORD_W-1:0] conv_code,
    input wire logic conv_over,
    // Control pins
    input wire logic output_disable,
    input wire logic power_down_n,
    input wire logic dither_en,
    input wire logic lsb_xor_scramble,
    input wire logic gain_select,
    input wire logic [1:0] mode_level,
    // Analog control outputs
    output logic analog_enable,
    output logic dither_active,
    output logic duty_stabilizer_en,
    output logic gain_high,
    // Data outputs
    output logic [PADC_WORD_W-1:0] sample_word,
    output logic sample_word_oe,
    output logic range_exceeded,
    output logic range_exceeded_oe,
    output logic data_valid_clk,
    output logic data_valid_clk_inv,
    output logic data_valid_oe
);

    typedef struct packed {
        padc_pins_t sync1;
        padc_pins_t sync2;
        padc_phase_t phase;
        padc_slot_t [PADC_LATENCY-1:0] pipe;
        padc_out_t out;
        logic dv;
        logic addr_valid;
        logic addr_write;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic freeze;
        logic [PADC_EV_W-1:0] status;
        logic [PADC_EV_W-1:0] mask;
        padc_out_t last;
        logic [31:0] count;
    } padc_state_t;

    padc_state_t s_q;
    padc_state_t s_d;

    // Offset binary becomes two's complement by inverting the MSB
    function automatic logic twos_coding(input logic [1:0] m);
        twos_coding = (m == PADC_MODE_TC_DCS) || (m == PADC_MODE_TC_NODCS);
    endfunction

    function automatic logic dcs_on(input logic [1:0] m);
        dcs_on = (m == PADC_MODE_OB_DCS) || (m == PADC_MODE_TC_DCS);
    endfunction

    padc_pins_t pins_raw;
    logic enc_high;
    logic enc_rise;
    logic running;
    logic drive_en;
    logic [PADC_WORD_W-1:0] merged;
    logic [PADC_WORD_W-1:0] coded;
    logic [PADC_WORD_W-1:0] stage_field [PADC_STAGES];
    logic [PADC_WORD_W-1:0] stage_keep [PADC_STAGES];
    logic bus_take;
    logic rd_status;
    logic [PADC_EV_W-1:0] events;

    assign pins_raw = '{
        enc_pos: encode_clock_pos,
        enc_neg: encode_clock_neg,
        output_disable: output_disable,
        power_down_n: power_down_n,
        dither_en: dither_en,
        scramble: lsb_xor_scramble,
        gain_select: gain_select,
        mode: mode_level
    };

    // Digital stand-in for the differential comparator on the encode pair
    assign enc_high = s_q.sync2.enc_pos & ~s_q.sync2.enc_neg;
    assign running = s_q.sync2.power_down_n;
    assign enc_rise = running && (s_q.phase == PADC_ENC_LOW) && enc_high;
    assign drive_en = ~s_q.sync2.output_disable & s_q.sync2.power_down_n;

    // Each stage resolves the top bits of the residue it receives
    generate
        for (genvar i = 0; i < PADC_STAGES; i++)
        begin : g_stage
            localparam int W = PADC_STAGE_W[i];
            localparam int L = PADC_STAGE_LSB[i];
            localparam logic [PADC_WORD_W-1:0] KEEP = PADC_WORD_W'(((1 << W) - 1) << L);
            assign stage_keep[i] = KEEP;
            assign stage_field[i] = s_q.pipe[i].residue & KEEP;
        end
    endgenerate

    // Correction logic: all five fields of one sample meet in the last slot
    assign merged = s_q.pipe[PADC_LATENCY-1].fields;

    always_comb
    begin
        coded = merged;
        if (twos_coding(s_q.sync2.mode))
        begin
            coded[PADC_WORD_W-1] = ~merged[PADC_WORD_W-1];
        end
        if (s_q.sync2.scramble)
        begin
            coded[PADC_WORD_W-1:1] = coded[PADC_WORD_W-1:1]
                ^ {(PADC_WORD_W-1){coded[0]}};
        end
    end

    assign bus_take = hsel && htrans[1] && hready;
    assign rd_status = bus_take && !hwrite && (haddr[7:0] == PADC_OFS_STATUS);

    always_comb
    begin
        events = '0;
        events[PADC_EV_WORD] = enc_rise;
        events[PADC_EV_RANGE] = enc_rise && s_q.pipe[PADC_LATENCY-1].over;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.sync1 = pins_raw;
        s_d.sync2 = s_q.sync1;

        // Encode phase tracking; a halted converter is parked in the low phase
        if (!running)
        begin
            s_d.phase = PADC_ENC_LOW;
        end
        else
        begin
            unique case (s_q.phase)
                PADC_ENC_LOW:
                begin
                    if (enc_high)
                    begin
                        s_d.phase = PADC_ENC_HIGH;
                    end
                end
                PADC_ENC_HIGH:
                begin
                    if (!enc_high)
                    begin
                        s_d.phase = PADC_ENC_LOW;
                    end
                end
                default:
                begin
                    s_d.phase = PADC_ENC_LOW;
                end
            endcase
        end

        // Pipeline advances only on the encode rise; edge 7 loads the output
        if (enc_rise)
        begin
            s_d.pipe[0].residue = conv_code;
            s_d.pipe[0].fields = '0;
            s_d.pipe[0].over = conv_over;
            for (int j = 1; j < PADC_LATENCY; j++)
            begin
                s_d.pipe[j] = s_q.pipe[j-1];
            end
            for (int k = 0; k < PADC_STAGES; k++)
            begin
                s_d.pipe[k+1].fields = s_q.pipe[k].fields | stage_field[k];
                s_d.pipe[k+1].residue = s_q.pipe[k].residue & ~stage_keep[k];
            end
            s_d.out.word = coded;
            s_d.out.over = s_q.pipe[PADC_LATENCY-1].over;
            s_d.count = s_q.count + 32'h0000_0001;
            if (!s_q.freeze)
            begin
                s_d.last = s_d.out;
            end
        end

        // Data valid follows the encode phase so its fall lands mid-window
        s_d.dv = running && (s_d.phase == PADC_ENC_HIGH);

        // AHB-Lite: zero wait, read data registered in the address phase
        s_d.addr_valid = bus_take;
        s_d.addr_write = bus_take && hwrite;
        s_d.addr = haddr[7:0];
        if (bus_take && !hwrite)
        begin
            unique case (haddr[7:0])
                PADC_OFS_CTRL: s_d.rdata = {31'h0, s_q.freeze};
                PADC_OFS_STATUS: s_d.rdata = {30'h0, s_q.status};
                PADC_OFS_MASK: s_d.rdata = {30'h0, s_q.mask};
                PADC_OFS_LAST: s_d.rdata = {15'h0, s_q.last.over, s_q.last.word};
                PADC_OFS_PINS: s_d.rdata = {23'h0, s_q.sync2};
                PADC_OFS_COUNT: s_d.rdata = s_q.count;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (s_q.addr_write)
        begin
            unique case (s_q.addr)
                PADC_OFS_CTRL: s_d.freeze = hwdata[0];
                PADC_OFS_MASK: s_d.mask = hwdata[PADC_EV_W-1:0];
                default: ;
            endcase
        end

        // Read clears status, but an event in the same cycle survives
        s_d.status = (rd_status ? '0 : s_q.status) | events;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '{
                sync1: '0,
                sync2: '0,
                phase: PADC_ENC_LOW,
                pipe: '0,
                out: '{word: PADC_WORD_RST, over: 1'b0},
                dv: 1'b0,
                addr_valid: 1'b0,
                addr_write: 1'b0,
                addr: 8'h00,
                rdata: 32'h0000_0000,
                freeze: PADC_FREEZE_RST,
                status: '0,
                mask: PADC_MASK_RST,
                last: '{word: PADC_WORD_RST, over: 1'b0},
                count: PADC_COUNT_RST
            };
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign irq = |(s_q.status & s_q.mask);

    assign analog_enable = s_q.sync2.power_down_n;
    assign dither_active = s_q.sync2.dither_en & s_q.sync2.power_down_n;
    assign duty_stabilizer_en = dcs_on(s_q.sync2.mode);
    assign gain_high = s_q.sync2.gain_select;

    assign sample_word = s_q.out.word;
    assign range_exceeded = s_q.out.over;
    assign data_valid_clk = s_q.dv;
    assign data_valid_clk_inv = ~s_q.dv;
    assign sample_word_oe = drive_en;
    assign range_exceeded_oe = drive_en;
    assign data_valid_oe = drive_en;

endmodule

// >>> bench/padc_output_ctrl_chk.sv
// Port assertions for the converter output control
`timescale 1ns/1ps
module padc_output_ctrl_chk
    import padc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control pins
    input wire logic output_disable,
    input wire logic power_down_n,
    input wire logic dither_en,
    input wire logic gain_select,
    input wire logic [1:0] mode_level,
    // Analog controls
    input wire logic analog_enable,
    input wire logic dither_active,
    input wire logic duty_stabilizer_en,
    input wire logic gain_high,
    // Data pins
    input wire logic [PADC_WORD_W-1:0] sample_word,
    input wire logic sample_word_oe,
    input wire logic range_exceeded,
    input wire logic range_exceeded_oe,
    input wire logic data_valid_clk,
    input wire logic data_valid_clk_inv,
    input wire logic data_valid_oe
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    dv_inverse_a: assert property (data_valid_clk_inv == !data_valid_clk)
        else $error("inverted valid not complement");
    oe_group_a: assert property (sample_word_oe == data_valid_oe &&
        range_exceeded_oe == data_valid_oe)
        else $error("output enables differ");
    // Four cycles cover the two-flop pin synchroniser
    oe_float_a: assert property (output_disable [*4] |-> !sample_word_oe)
        else $error("outputs driven while disabled");
    pd_float_a: assert property (!power_down_n [*4] |-> !data_valid_oe && !analog_enable)
        else $error("outputs or analog on in power down");
    dither_ctl_a: assert property ($stable({dither_en, power_down_n}) [*4]
        |-> dither_active == (dither_en && power_down_n))
        else $error("dither state wrong");
    mode_dcs_a: assert property ($stable(mode_level) [*4]
        |-> duty_stabilizer_en == (mode_level == 2'h1 || mode_level == 2'h2))
        else $error("duty stabilizer wrong for mode");
    gain_sel_a: assert property ($stable(gain_select) [*4] |-> gain_high == gain_select)
        else $error("gain select not followed");
    word_move_a: assert property ($changed({range_exceeded, sample_word})
        |-> $rose(data_valid_clk))
        else $error("word changed without valid rise");
    dv_fall_a: assert property ($rose(data_valid_clk) |-> ##[1:40] $fell(data_valid_clk))
        else $error("data valid stuck high");
endmodule

bind padc_output_ctrl padc_output_ctrl_chk u_chk (.hclk, .hresetn, .output_disable, .power_down_n,
    .dither_en, .gain_select, .mode_level, .analog_enable, .dither_active, .duty_stabilizer_en,
    .gain_high, .sample_word, .sample_word_oe, .range_exceeded, .range_exceeded_oe,
    .data_valid_clk, .data_valid_clk_inv, .data_valid_oe);

// >>> bench/padc_capture_model.sv
// Capture logic model latching words from the data pins
`timescale 1ns/1ps
module padc_capture_model
    import padc_pkg::*;
(
    // Data pins
    input wire logic [PADC_WORD_W-1:0] sample_word,
    input wire logic range_exceeded,
    input wire logic data_valid_clk,
    input wire logic data_valid_clk_inv,
    // Receiver setting
    input wire logic descramble,
    // Captured word
    output padc_out_t cap,
    output logic cap_tog
);
    initial cap_tog = 1'b0;
    always @(negedge data_valid_clk)
    begin
        cap.word <= sample_word ^ ({PADC_WORD_W{descramble & sample_word[0]}} & 16'hFFFE);
        cap_tog <= ~cap_tog;
    end
    // Flag taken on the inverted clock, so a broken complement loses it
    always @(posedge data_valid_clk_inv)
        cap.over <= range_exceeded;
endmodule

// >>> bench/tb_pipelined_adc_output_control.sv
// Self-checking bench for the converter output control
`timescale 1ns/1ps
module tb_pipelined_adc_output_control
    import padc_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq, cap_tog;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, mode_level = 0;
    logic [2:0] hsize = 3'h2;
    logic encode_clock_pos = 0, conv_over = 0, output_disable = 0, power_down_n = 1;
    logic dither_en = 0, lsb_xor_scramble = 0, gain_select = 0;
    logic [PADC_WORD_W-1:0] conv_code = 0, sample_word;
    logic analog_enable, dither_active, duty_stabilizer_en, gain_high, sample_word_oe;
    logic range_exceeded, range_exceeded_oe, data_valid_clk, data_valid_clk_inv, data_valid_oe;
    padc_out_t cap, e, x;
    padc_out_t q[$];
    int n_mismatch = 0, cmp_count = 0, seed = 30873, rises = 0, n_cap = 0;
    always #4 hclk = ~hclk;
    padc_output_ctrl u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .encode_clock_pos,
        .encode_clock_neg(~encode_clock_pos), .conv_code, .conv_over, .output_disable,
        .power_down_n, .dither_en, .lsb_xor_scramble, .gain_select, .mode_level, .analog_enable,
        .dither_active, .duty_stabilizer_en, .gain_high, .sample_word, .sample_word_oe,
        .range_exceeded, .range_exceeded_oe, .data_valid_clk, .data_valid_clk_inv, .data_valid_oe);
    padc_capture_model u_cap (.sample_word, .range_exceeded, .data_valid_clk, .data_valid_clk_inv,
        .descramble(lsb_xor_scramble), .cap, .cap_tog);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wt;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1)
        begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wt();
        rd = hrdata;
    endtask
    // Encode runs free of hclk; the odd offset keeps its edges off the clock edges
    task automatic enc(input int n);
        @(posedge hclk);
        #3.3;
        repeat (n)
        begin
            conv_code = $random(seed);
            conv_over = $random(seed);
            if (rises % 5 == 2)
                conv_code = 16'h8000;
            if (rises % 5 == 3)
                conv_code = 16'h7FFF;
            #62.5 encode_clock_pos = 1'b1;
            if (power_down_n)
            begin
                rises++;
                e.word = mode_level[1] ? conv_code ^ 16'h8000 : conv_code;
                e.over = conv_over;
                q.push_back(e);
            end
            #62.5 encode_clock_pos = 1'b0;
        end
    endtask
    // First seven captures after a restart still hold older samples
    always @(cap_tog)
    begin
        #1;
        if (q.size() > 7)
        begin
            x = q.pop_front();
            n_cap++;
            chk("word", cap.word, x.word);
            chk("over", cap.over, x.over);
        end
    end
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, PADC_OFS_MASK, 0);
        chk("mask", rd, 32'h0);
        ahb(0, PADC_OFS_CTRL, 0);
        chk("ctrl", rd, 32'h0);
        ahb(0, 8'h40, 0);
        chk("unmapped", rd, 32'h0);
        $display("test registers done");
        for (int m = 0; m < 8; m++)
        begin
            mode_level <= m[1:0];
            lsb_xor_scramble <= m[2];
            dither_en <= $random(seed);
            gain_select <= $random(seed);
            repeat (6) @(posedge hclk);
            chk("dcs", duty_stabilizer_en, m[1] ^ m[0]);
            chk("gain", gain_high, gain_select);
            chk("dither", dither_active, dither_en);
            q.delete();
            enc(12);
            repeat (10) @(posedge hclk);
            $display("test format %0d done", m);
        end
        ahb(0, PADC_OFS_PINS, 0);
        // Encode parked low, powered, scramble on, mode 3
        chk("pins", rd, {23'h0, 4'h5, dither_en, 1'b1, gain_select, 2'h3});
        chk("hresp", hresp, 1'b0);
        chk("captures", n_cap, 40);
        ahb(0, PADC_OFS_COUNT, 0);
        chk("count", rd, rises);
        power_down_n <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("analog", analog_enable, 1'b0);
        chk("pd oe", sample_word_oe, 1'b0);
        enc(4);
        ahb(0, PADC_OFS_COUNT, 0);
        chk("pd count", rd, rises);
        power_down_n <= 1'b1;
        output_disable <= 1'b1;
        repeat (6) @(posedge hclk);
        chk("od oe", sample_word_oe, 1'b0);
        output_disable <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("oe", sample_word_oe, 1'b1);
        $display("test enables done");
        chk("irq masked", irq, 1'b0);
        ahb(1, PADC_OFS_MASK, 32'h1);
        @(posedge hclk);
        chk("irq", irq, 1'b1);
        ahb(0, PADC_OFS_STATUS, 0);
        chk("status", rd[0], 1'b1);
        ahb(0, PADC_OFS_STATUS, 0);
        chk("status clr", rd[0], 1'b0);
        chk("irq clr", irq, 1'b0);
        $display("test interrupt done");
        results();
    end
endmodule
